// ### core/susp_pkg.sv
package susp_pkg;
  // Power modes requested by the partner
  typedef enum logic [2:0] {
    PM_RUN      = 3'h0,
    PM_PLANESON = 3'h1,
    PM_PLANESOFF = 3'h3,
    PM_OFF      = 3'h2
  } pmState_t;

  // Request codes from the partner
  localparam logic [1:0] REQ_POS = 2'h0;
  localparam logic [1:0] REQ_STR = 2'h1;
  localparam logic [1:0] REQ_STD = 2'h2;
  localparam logic [1:0] REQ_SOFT_OFF = 2'h3;

  // Exit latency targets, kept for reference by software timers
  localparam int DSC_EXIT_MS = 10;
  localparam int STR_EXIT_MS = 1000;
  localparam int STD_EXIT_MS = 30000;

  localparam int CLK_SYS_MHZ = 40;
  // Refresh interval in suspend clock edges
  localparam int REFRESH_DIV = 4;
  localparam logic [7:0] DRAM_CFG_RST = 8'h00;
  localparam logic [7:0] STATE_RST = 8'h00;
endpackage

// ### core/sync2.sv
module sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ### core/suspend_power_state_control.sv
module suspend_power_state_control (
  // Clock and resume-well reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // PCI bus reset, core well only, synchronous level
  input  wire logic       pciResetN,
  // Activity indications
  input  wire logic       hostBusIdle,
  input  wire logic       pciBusIdle,
  input  wire logic       internalIdle,
  input  wire logic       testMode,
  input  wire logic       accessReq,
  // Partner link
  input  wire logic       suspend_clock,
  input  wire logic       suspend_status_n,
  input  wire logic [1:0] suspendReq,
  input  wire logic       cpu_stop_clock,
  // DRAM configuration load
  input  wire logic       cfgWrite,
  input  wire logic [7:0] cfgData,
  // Status and controls
  output logic            standby_q,
  output logic            accessGo_q,
  output logic            arbiterEn_q,
  output logic            suspRefresh_q,
  output logic            refreshStrobe_q,
  output logic            cpuIfEn_q,
  output logic            pciIfEn_q,
  output logic            planesOn_q,
  output logic            chipOff_q,
  output logic            coreResetN_q,
  output logic            resumeReset_q,
  output logic [7:0]      dramCfg_q,
  output logic [2:0]      pmState_q
);
  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [4:0] linkSync;
  logic       clkS;
  logic       statS;
  logic       stopS;
  logic [1:0] reqS;
  logic       statPrev_q;
  logic       clkPrev_q;
  logic       statRise;
  logic       susClkRise;
  susp_pkg::pmState_t st_q;
  logic       inSuspend_q;
  logic [2:0] refDiv_q;

  sync2 #(.W(5)) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    // Status enters inverted so the flop reset matches its idle level
    .din     ({cpu_stop_clock, suspendReq, suspend_clock,
               !suspend_status_n}),
    .dout    (linkSync)
  );
  assign stopS = linkSync[4];
  assign reqS  = linkSync[3:2];
  assign clkS  = linkSync[1];
  assign statS = !linkSync[0];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // Idle high, so no false release edge follows reset
      statPrev_q <= 1'b1;
      clkPrev_q  <= 1'b0;
    end else begin
      statPrev_q <= statS;
      clkPrev_q  <= clkS;
    end
  end
  // Single-cycle pulse: clock level is judged on this edge only
  assign statRise   = statS && !statPrev_q;
  assign susClkRise = clkS && !clkPrev_q;

  // ---------------------------------------------------------------
  // Power sequencing, resume well
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q        <= susp_pkg::PM_RUN;
      inSuspend_q <= 1'b0;
    end else begin
      case (st_q)
        susp_pkg::PM_RUN: begin
          if (!statS) begin
            inSuspend_q <= 1'b1;
            case (reqS)
              susp_pkg::REQ_POS: st_q <= susp_pkg::PM_PLANESON;
              susp_pkg::REQ_STR: st_q <= susp_pkg::PM_PLANESOFF;
              default:           st_q <= susp_pkg::PM_OFF;
            endcase
          end
        end
        susp_pkg::PM_PLANESON,
        susp_pkg::PM_PLANESOFF,
        susp_pkg::PM_OFF: begin
          if (statRise) begin
            st_q        <= susp_pkg::PM_RUN;
            inSuspend_q <= 1'b0;
          end
        end
        default: st_q <= susp_pkg::PM_RUN;
      endcase
    end
  end

  // Resume-well reset pulse and DRAM configuration
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resumeReset_q <= 1'b0;
      dramCfg_q     <= susp_pkg::DRAM_CFG_RST;
    end else begin
      resumeReset_q <= statRise && !clkS;
      if (statRise && !clkS) begin
        dramCfg_q <= susp_pkg::DRAM_CFG_RST;
      end else if (cfgWrite && coreResetN_q) begin
        dramCfg_q <= cfgData;
      end
    end
  end

  // ---------------------------------------------------------------
  // Refresh
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      suspRefresh_q   <= 1'b0;
      refDiv_q        <= 3'h0;
      refreshStrobe_q <= 1'b0;
    end else begin
      refreshStrobe_q <= 1'b0;
      // Normal refresh on any release, and as soon as stop clock ends outside PM_PLANESON and PM_PLANESOFF
      if (statRise) begin
        suspRefresh_q <= 1'b0;
      end else begin
        suspRefresh_q <= stopS ||
                         st_q == susp_pkg::PM_PLANESON ||
                         st_q == susp_pkg::PM_PLANESOFF;
      end
      // Suspend refresh is timed only from suspend clock edges
      if (suspRefresh_q && susClkRise) begin
        if (refDiv_q == 3'(susp_pkg::REFRESH_DIV - 1)) begin
          refDiv_q        <= 3'h0;
          refreshStrobe_q <= 1'b1;
        end else begin
          refDiv_q <= refDiv_q + 3'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Interface enables and planes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpuIfEn_q   <= 1'b1;
      pciIfEn_q   <= 1'b1;
      planesOn_q  <= 1'b1;
      chipOff_q   <= 1'b0;
      arbiterEn_q <= 1'b1;
      pmState_q   <= 3'h0;
    end else begin
      pmState_q   <= st_q;
      arbiterEn_q <= !stopS && st_q == susp_pkg::PM_RUN;
      cpuIfEn_q   <= st_q != susp_pkg::PM_PLANESOFF &&
                     st_q != susp_pkg::PM_OFF;
      pciIfEn_q   <= st_q != susp_pkg::PM_PLANESOFF &&
                     st_q != susp_pkg::PM_OFF;
      planesOn_q  <= st_q != susp_pkg::PM_OFF;
      chipOff_q   <= st_q == susp_pkg::PM_OFF;
    end
  end

  // ---------------------------------------------------------------
  // Core well: reset by PCI reset and on leaving RAM suspend
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      coreResetN_q <= 1'b0;
    end else begin
      coreResetN_q <= pciResetN &&
                      !(statRise && st_q == susp_pkg::PM_PLANESOFF);
    end
  end

  // ---------------------------------------------------------------
  // Chip standby, no timer; wakes on the clock edge after a request
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      standby_q  <= 1'b0;
      accessGo_q <= 1'b0;
    end else begin
      standby_q  <= hostBusIdle && pciBusIdle && internalIdle &&
                    !testMode && pciResetN && coreResetN_q &&
                    !accessReq;
      accessGo_q <= accessReq && coreResetN_q;
    end
  end
endmodule

// ### verif/spsc_props.sv
module spsc_checker (
  // Watched ports
  input wire logic       clk_sys, rstn, pciResetN, hostBusIdle,
  input wire logic       pciBusIdle, internalIdle, testMode, accessReq,
  input wire logic       suspend_clock, suspend_status_n, standby_q,
  input wire logic       accessGo_q, coreResetN_q, resumeReset_q,
  input wire logic       planesOn_q,
  input wire logic [7:0] dramCfg_q,
  input wire logic [2:0] pmState_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire logic idle = hostBusIdle && pciBusIdle && internalIdle
    && !testMode && pciResetN;
  sequence relHi; $rose(suspend_status_n) && suspend_clock; endsequence
  sequence relLo; $rose(suspend_status_n) && !suspend_clock; endsequence
  stby_cause_a: assert property (!$past(idle) |-> !standby_q)
    else $error("standby while busy");
  stby_entry_a: assert property ((idle && !accessReq && suspend_status_n
    && pmState_q == 3'h0)[*3] |-> standby_q)
    else $error("standby late");
  access_go_a: assert property (accessReq |=> accessGo_q)
    else $error("access delayed");
  keep_well_a: assert property (relHi |-> ##1 !resumeReset_q[*5])
    else $error("well reset on high clock");
  well_reset_a: assert property (relLo |-> ##[2:4] resumeReset_q)
    else $error("no well reset");
  reset_once_a: assert property (resumeReset_q |=> !resumeReset_q[*3])
    else $error("well reset repeated");
  cfg_default_a: assert property (resumeReset_q
    |-> ##[0:1] dramCfg_q == 8'h00)
    else $error("config kept");
  core_reset_a: assert property (!pciResetN |=> !coreResetN_q)
    else $error("core not reset");
  well_hold_a: assert property (!coreResetN_q ##1 !resumeReset_q
    |-> $stable(dramCfg_q))
    else $error("config lost in core reset");
  planes_on_a: assert property (pmState_q == 3'h1 |-> planesOn_q)
    else $error("plane dropped");
  core_wipe_a: assert property (pmState_q == 3'h3 ##1 pmState_q == 3'h0
    |-> !$past(coreResetN_q))
    else $error("core kept after ram suspend");
endmodule
bind suspend_power_state_control spsc_checker chk_i (.*);

// ### verif/susp_partner.sv
module susp_partner (
  // Link
  output logic       suspend_clock,
  output logic       suspend_status_n,
  output logic [1:0] suspendReq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1'b0;
  // System cache state: flushed before suspend, rebuilt after
  logic cacheValid = 1'b1;
  initial begin
    suspend_clock = 1'b0;
    suspend_status_n = 1'b1;
    suspendReq = 2'h0;
  end
  // Slow clock stands low outside suspend
  always begin
    wait (run);
    #100 suspend_clock = 1'b1;
    #100 suspend_clock = 1'b0;
  end
  task automatic enter(input logic [1:0] r);
    cacheValid = 1'b0;
    suspendReq = r;
    run = 1'b1;
    #300 suspend_status_n = 1'b0;
  endtask
  task automatic leave(input logic keep);
    if (keep) begin
      @(posedge suspend_clock);
      #30 suspend_status_n = 1'b1;
    end else begin
      run = 1'b0;
      wait (!suspend_clock);
      #200 suspend_status_n = 1'b1;
    end
    run = 1'b0;
    cacheValid = 1'b1;
  endtask
endmodule

// ### verif/tb_suspend_power_state_control.sv
module tb_suspend_power_state_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rstn, pciResetN, hostBusIdle, pciBusIdle, internalIdle;
  logic testMode, accessReq, cpu_stop_clock, cfgWrite, suspend_clock;
  logic suspend_status_n, standby_q, accessGo_q, arbiterEn_q;
  logic suspRefresh_q, refreshStrobe_q, cpuIfEn_q, pciIfEn_q;
  logic planesOn_q, chipOff_q, coreResetN_q, resumeReset_q;
  logic [1:0] suspendReq;
  logic [7:0] cfgData, dramCfg_q;
  logic [2:0] pmState_q;
  int err_total = 0, check_count = 0, cyc = 0, nStr = 0;
  suspend_power_state_control dut (.*);
  susp_partner pm (.*);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the longest run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // Strobe counted away from the edge that launches it
  always @(negedge clk_sys) begin
    if (refreshStrobe_q === 1'b1) nStr++;
  end
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic cfg(input logic [7:0] d);
    cfgData = d;
    cfgWrite = 1'b1;
    cyc_n(1);
    cfgWrite = 1'b0;
    cyc_n(1);
  endtask
  task automatic t_standby();
    cyc_n(4);
    chk(standby_q === 1'b1, "no standby");
    accessReq = 1'b1;
    cyc_n(1);
    chk(accessGo_q === 1'b1, "access late");
    accessReq = 1'b0;
    testMode = 1'b1;
    cyc_n(3);
    chk(standby_q === 1'b0, "standby in test");
    testMode = 1'b0;
    $display("standby test done");
  endtask
  task automatic t_stopclk();
    cpu_stop_clock = 1'b1;
    cyc_n(4);
    chk(arbiterEn_q === 1'b0 && suspRefresh_q === 1'b1, "no stop");
    cpu_stop_clock = 1'b0;
    cyc_n(4);
    chk(arbiterEn_q === 1'b1 && suspRefresh_q === 1'b0, "stop kept");
    $display("stop clock test done");
  endtask
  task automatic t_susp(input logic [1:0] r, input logic keep,
                        input susp_pkg::pmState_t st);
    cfg(8'h5a);
    nStr = 0;
    pm.enter(r);
    cyc_n(60);
    chk(pmState_q === st, "mode map");
    chk(suspRefresh_q === (r < 2'h2), "susp refresh");
    case (r)
      2'h0: chk(planesOn_q === 1'b1 && nStr > 0, "planes");
      2'h1: chk({cpuIfEn_q, pciIfEn_q} === 2'h0 && nStr > 0, "iso");
      default: chk(chipOff_q === 1'b1, "chip on");
    endcase
    pm.leave(keep);
    cyc_n(8);
    chk(pmState_q === susp_pkg::PM_RUN, "no run");
    chk(suspRefresh_q === 1'b0, "refresh kept");
    chk(dramCfg_q === (keep ? 8'h5a : 8'h00), "well");
    $display("suspend test done");
  endtask
  task automatic t_pcirst();
    cfg(8'h3c);
    pciResetN = 1'b0;
    cyc_n(3);
    chk(coreResetN_q === 1'b0, "core live");
    cfg(8'hc3);
    chk(dramCfg_q === 8'h3c, "write in reset");
    pciResetN = 1'b1;
    cyc_n(3);
    chk(dramCfg_q === 8'h3c, "well lost");
    $display("pci reset test done");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {rstn, testMode, accessReq, cpu_stop_clock, cfgWrite} = 5'h0;
    {pciResetN, hostBusIdle, pciBusIdle, internalIdle} = 4'hf;
    cfgData = 8'h00;
    repeat (20) @(posedge clk_sys);
    #2 rstn = 1'b1;
    cyc_n(2);
    t_standby();
    t_stopclk();
    t_susp(susp_pkg::REQ_POS, 1'b1, susp_pkg::PM_PLANESON);
    t_susp(susp_pkg::REQ_STR, 1'b1, susp_pkg::PM_PLANESOFF);
    t_susp(susp_pkg::REQ_STD, 1'b0, susp_pkg::PM_OFF);
    t_susp(susp_pkg::REQ_SOFT_OFF, 1'b0, susp_pkg::PM_OFF);
    t_pcirst();
    close_out();
  end
endmodule
